// [rtl/sfs_latch.sv]
// Second-function source select latch pair with setting selection
module sfs_latch (
    // Clock, reset and the enable level
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire logic            enable,
    // Host write port and latch readback
    input  wire sfs_pkg::sfs_wr_t wr,
    input  wire logic      [7:0] rd_addr,
    output logic           [7:0] rd_data,
    // Resistor readings, taken on the enable rising edge
    input  wire logic      [7:0] res_freq,
    input  wire logic      [7:0] res_load,
    input  wire logic      [7:0] res_ovc,
    input  wire logic      [7:0] res_zone,
    input  wire logic      [7:0] res_shed1,
    input  wire logic      [7:0] res_shed2,
    input  wire logic      [7:0] res_shed3,
    input  wire logic      [7:0] res_shed4,
    // Selection in force and the chosen settings
    output sfs_pkg::sfs_sel_t    active_sel,
    output logic           [7:0] switching_freq,
    output logic           [7:0] load_line,
    output logic           [7:0] overcurrent_limit,
    output logic           [7:0] low_power_zone,
    output logic           [7:0] shed_threshold1,
    output logic           [7:0] shed_threshold2,
    output logic           [7:0] shed_threshold3,
    output logic           [7:0] shed_threshold4
);
    // Slot map, shared by the resistor and register paths:
    //   slot 0  switching frequency, source bit 5
    //   slot 1  load-line fraction, source bit 4
    //   slot 2  overcurrent threshold, source bit 2
    //   slot 3  low-power zones, source bit 1
    //   slot 4  shed threshold 1, source bit 0
    //   slot 5  shed threshold 2, source bit 0
    //   slot 6  shed threshold 3, source bit 0
    //   slot 7  shed threshold 4, source bit 0
    //
    // Mode change handshake:
    //   The host writes one byte to each latch, either order.
    //   Until both hold the same masked byte, every slot stays on
    //   its resistor value; a half-written mode never takes effect.
    //   A single stray write therefore drops register control for
    //   all slots, which is the safe side for a power stage.
    //
    // Enable handling:
    //   Any change of enable clears both latches, so each power-up
    //   starts on resistor control whatever the host left behind.
    //   A rising edge also re-samples all eight resistor readings.
    //   A latch write that meets a toggle in one cycle is lost;
    //   the host must repeat it after the enable edge.
    //
    // Timing:
    //   Latch write at edge n, readback right after edge n.
    //   Selection follows at once from the latch contents.
    //   Setting outputs are registered, one edge later.
    //
    // Reset:
    //   Latches, stores, samples and outputs all go to zero.
    //   Outputs on resistor control read zero until the first enable rising edge.
    //
    // Reserved bits:
    //   Bits 7, 6 and 3 are masked on the way in, so no stray
    //   host byte can reach a reserved position or the compare.
    //
    // Limitations:
    //   Config registers are write-only stores here; their readback
    //   belongs to the register file outside this block.
    //   Resistor readings are taken as settled at the enable edge;
    //   the analog conversion ahead of them is not modelled.

    localparam int NSET = 8;

    // Latch pair and enable history
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic       enable_q;

    // Per-slot storage and routing
    logic [7:0] cfg_reg  [NSET];
    logic [7:0] sampled  [NSET];
    logic [7:0] res_in   [NSET];
    logic [7:0] cfg_addr [NSET];
    logic [NSET-1:0] use_reg;
    logic [7:0] picked   [NSET];


    // Enable edges and latch write decode
    wire enable_toggle = enable ^ enable_q;
    wire enable_rise   = enable & ~enable_q;
    wire wr_a = wr.valid && (wr.addr == sfs_pkg::ADDR_LATCH_A);
    wire wr_b = wr.valid && (wr.addr == sfs_pkg::ADDR_LATCH_B);
    // Reserved positions are never stored, so they read zero
    wire [7:0] wr_byte = wr.data & sfs_pkg::LATCH_MASK;
    // Selection acts only once both latches agree
    wire        agree  = (latch_a == latch_b);
    wire [7:0] eff_sel = agree ? latch_a : sfs_pkg::BYTE_ZERO;


    // Latch pair; an enable toggle wins over a same-cycle write
    always_ff @(posedge ref_clk) begin
        enable_q <= enable;
        if (reset || enable_toggle) begin
            latch_a <= sfs_pkg::LATCH_RESET;
            latch_b <= sfs_pkg::LATCH_RESET;
        end else begin
            if (wr_a) begin
                latch_a <= wr_byte;
            end
            if (wr_b) begin
                latch_b <= wr_byte;
            end
        end
    end


    // Fixed maps from setting slot to resistor input and register
    assign res_in[0] = res_freq;
    assign res_in[1] = res_load;
    assign res_in[2] = res_ovc;
    assign res_in[3] = res_zone;
    assign res_in[4] = res_shed1;
    assign res_in[5] = res_shed2;
    assign res_in[6] = res_shed3;
    assign res_in[7] = res_shed4;
    assign cfg_addr[0] = sfs_pkg::ADDR_FREQ_CFG;
    assign cfg_addr[1] = sfs_pkg::ADDR_LOAD_CFG;
    assign cfg_addr[2] = sfs_pkg::ADDR_OVC_CFG;
    assign cfg_addr[3] = sfs_pkg::ADDR_ZONE_CFG;
    assign cfg_addr[4] = sfs_pkg::ADDR_SHED1_CFG;
    assign cfg_addr[5] = sfs_pkg::ADDR_SHED2_CFG;
    assign cfg_addr[6] = sfs_pkg::ADDR_SHED3_CFG;
    assign cfg_addr[7] = sfs_pkg::ADDR_SHED4_CFG;


    // Source bit per slot; all four shed slots share one bit
    assign use_reg[0] = eff_sel[sfs_pkg::BIT_FREQ];
    assign use_reg[1] = eff_sel[sfs_pkg::BIT_LOAD];
    assign use_reg[2] = eff_sel[sfs_pkg::BIT_OVC];
    assign use_reg[3] = eff_sel[sfs_pkg::BIT_ZONE];
    assign use_reg[7:4] = {4{eff_sel[sfs_pkg::BIT_SHED]}};


    // Per slot: config register, resistor sample and chooser
    genvar g;
    generate
        for (g = 0; g < NSET; g++) begin : g_slot
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    cfg_reg[g] <= sfs_pkg::BYTE_ZERO;
                    sampled[g] <= sfs_pkg::BYTE_ZERO;
                end else begin
                    if (wr.valid && wr.addr == cfg_addr[g]) begin
                        cfg_reg[g] <= wr.data;
                    end
                    // Resistor reading held from the enable edge
                    if (enable_rise) begin
                        sampled[g] <= res_in[g];
                    end
                end
            end
            sfs_pick u_pick (
                .use_reg (use_reg[g]),
                .res_val (sampled[g]),
                .reg_val (cfg_reg[g]),
                .value   (picked[g])
            );
        end
    endgenerate


    // Settings out, registered so they never glitch on a write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            switching_freq    <= sfs_pkg::BYTE_ZERO;
            load_line         <= sfs_pkg::BYTE_ZERO;
            overcurrent_limit <= sfs_pkg::BYTE_ZERO;
            low_power_zone    <= sfs_pkg::BYTE_ZERO;
            shed_threshold1   <= sfs_pkg::BYTE_ZERO;
            shed_threshold2   <= sfs_pkg::BYTE_ZERO;
            shed_threshold3   <= sfs_pkg::BYTE_ZERO;
            shed_threshold4   <= sfs_pkg::BYTE_ZERO;
        end else begin
            switching_freq    <= picked[0];
            load_line         <= picked[1];
            overcurrent_limit <= picked[2];
            low_power_zone    <= picked[3];
            shed_threshold1   <= picked[4];
            shed_threshold2   <= picked[5];
            shed_threshold3   <= picked[6];
            shed_threshold4   <= picked[7];
        end
    end


    // Selection flags as in force right now
    assign active_sel.freq        = use_reg[0];
    assign active_sel.load_line   = use_reg[1];
    assign active_sel.overcurrent = use_reg[2];
    assign active_sel.zone        = use_reg[3];
    assign active_sel.shed        = use_reg[4];


    // Readback of the latch pair; other addresses read zero
    assign rd_data = (rd_addr == sfs_pkg::ADDR_LATCH_A) ? latch_a :
                     (rd_addr == sfs_pkg::ADDR_LATCH_B) ? latch_b :
                     sfs_pkg::BYTE_ZERO;
endmodule

// [rtl/sfs_pkg.sv]
// Package for the second-function source select latch pair
package sfs_pkg;
    // Register addresses on the configuration write port
    localparam logic [7:0] ADDR_LATCH_A     = 8'h46;
    localparam logic [7:0] ADDR_LATCH_B     = 8'h47;
    localparam logic [7:0] ADDR_FREQ_CFG    = 8'h30;
    localparam logic [7:0] ADDR_LOAD_CFG    = 8'h39;
    localparam logic [7:0] ADDR_OVC_CFG     = 8'h2e;
    localparam logic [7:0] ADDR_ZONE_CFG    = 8'h36;
    localparam logic [7:0] ADDR_SHED1_CFG   = 8'h3a;
    localparam logic [7:0] ADDR_SHED2_CFG   = 8'h3c;
    localparam logic [7:0] ADDR_SHED3_CFG   = 8'h3e;
    localparam logic [7:0] ADDR_SHED4_CFG   = 8'h40;
    // Bit positions in both latches
    localparam int BIT_FREQ  = 5;
    localparam int BIT_LOAD  = 4;
    localparam int BIT_OVC   = 2;
    localparam int BIT_ZONE  = 1;
    localparam int BIT_SHED  = 0;
    // Writable bits; 7, 6 and 3 are reserved
    localparam logic [7:0] LATCH_MASK  = 8'h37;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // One write on the configuration port
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } sfs_wr_t;

    // Per-setting source choice, 1 means register
    typedef struct packed {
        logic freq;
        logic load_line;
        logic overcurrent;
        logic zone;
        logic shed;
    } sfs_sel_t;
endpackage

// [rtl/sfs_pick.sv]
// Two-way chooser between resistor-sampled and register value
module sfs_pick (
    input  wire logic       use_reg,
    input  wire logic [7:0] res_val,
    input  wire logic [7:0] reg_val,
    output logic      [7:0] value
);
    // Register value only when its source bit is set
    assign value = use_reg ? reg_val : res_val;
endmodule

// [bench/sfs_host.sv]
// Host model driving the configuration write port
module sfs_host (
    input  wire logic        ref_clk,
    output sfs_pkg::sfs_wr_t wr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial wr = '0;
    // One write from a falling edge to the next; released lines are
    // inverted so a stale address cannot pass for a live one
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        wr = '{1'b1, a, d};
        @(negedge ref_clk);
        wr = '{1'b0, ~a, ~d};
    endtask
    // Mode change: same byte to both latches, either order, any gap
    task automatic mode(input logic [7:0] b, input bit ba, input int gap);
        put(ba ? 8'h47 : 8'h46, b);
        repeat (gap) @(negedge ref_clk);
        put(ba ? 8'h46 : 8'h47, b);
    endtask
endmodule

// [bench/sfs_latch_chk.sv]
// Concurrent checks on the source select latch pair
module sfs_latch_chk (
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              enable,
    input wire sfs_pkg::sfs_wr_t  wr,
    input wire logic        [7:0] rd_addr,
    input wire logic        [7:0] rd_data,
    input wire logic        [7:0] res_freq,
    input wire logic        [7:0] res_shed4,
    input wire sfs_pkg::sfs_sel_t active_sel,
    input wire logic        [7:0] switching_freq,
    input wire logic        [7:0] shed_threshold4
);
    timeunit 1ns;
    timeprecision 100ps;
    // One domain, so clock and reset are given once
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_rsv; rd_addr[7:1]==7'h23 |-> !(rd_data & 8'hc8); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read");
    property p_unm; rd_addr[7:1]!=7'h23 |-> rd_data==8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_wr; wr.valid && wr.addr[7:1]==7'h23 && $stable(enable) |=>
        rd_addr!=$past(wr.addr) || rd_data==($past(wr.data) & 8'h37);
    endproperty
    a_wr: assert property (p_wr) else $error("latch write lost");
    // Selection moves only after a latch write, unless enable toggled
    property p_src; $changed(active_sel) && $past(enable)==$past(enable, 2)
        |-> $past(wr.valid) && $past(wr.addr[7:1])==7'h23; endproperty
    a_src: assert property (p_src) else $error("stray select");
    property p_clr; $changed(enable) |=> active_sel==5'h00; endproperty
    a_clr: assert property (p_clr) else $error("toggle kept mode");
    property p_hold; (!active_sel.freq && $stable(enable))[*2] |=>
        $stable(switching_freq); endproperty
    a_hold: assert property (p_hold) else $error("freq moved");
    property p_fres; $rose(enable) |=> ##1
        switching_freq==$past(res_freq, 2); endproperty
    a_fres: assert property (p_fres) else $error("freq sample");
    property p_sres; $rose(enable) |=> ##1
        shed_threshold4==$past(res_shed4, 2); endproperty
    a_sres: assert property (p_sres) else $error("shed sample");
    // Main scenarios
    c_sel: cover property (active_sel.freq);
    c_fall: cover property ($fell(enable));
    c_rise: cover property ($rose(enable));
endmodule
bind sfs_latch sfs_latch_chk u_chk (.*);

// [bench/second_function_source_select_tb_top.sv]
// Self-checking bench for the source select latch pair
module second_function_source_select_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, reset = 1'b1, enable = 1'b0;
    logic [7:0] rd_addr = 8'h46, b, res [8], cfg [8];
    logic [11:0] e, q [$];
    int n_errors = 0, n_compared = 0, seed = 44;
    wire [7:0] o [9];
    sfs_pkg::sfs_wr_t wr;
    sfs_pkg::sfs_sel_t sel;
    localparam logic [7:0] ADR [8] = '{8'h30, 8'h39, 8'h2e, 8'h36,
                                      8'h3a, 8'h3c, 8'h3e, 8'h40};
    localparam int BT [8] = '{5, 4, 2, 1, 0, 0, 0, 0};
    sfs_host host (.ref_clk(ref_clk), .wr(wr));
    sfs_latch dut (.ref_clk(ref_clk), .reset(reset), .enable(enable),
        .wr(wr), .rd_addr(rd_addr), .rd_data(o[0]), .res_freq(res[0]),
        .res_load(res[1]), .res_ovc(res[2]), .res_zone(res[3]),
        .res_shed1(res[4]), .res_shed2(res[5]), .res_shed3(res[6]),
        .res_shed4(res[7]), .active_sel(sel), .switching_freq(o[1]),
        .load_line(o[2]), .overcurrent_limit(o[3]), .low_power_zone(o[4]),
        .shed_threshold1(o[5]), .shed_threshold2(o[6]),
        .shed_threshold3(o[7]), .shed_threshold4(o[8]));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Notes the readback at rd_addr, selection and the eight chosen settings
    task automatic expect_all(input logic [7:0] rd, input logic [7:0] s);
        q.push_back({4'h0, rd & 8'h37});
        q.push_back({4'h9, 3'h0, s[5:4], s[2:0]});
        for (int i = 0; i < 8; i++) begin
            b = s[BT[i]] ? cfg[i] : res[i];
            q.push_back({4'(i + 1), b});
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Notes are judged at the next rising edge, before it updates
    always @(posedge ref_clk)
        while (q.size() > 0) begin
            e = q.pop_front();
            check(e[11:8] == 4'h9 ? {3'h0, sel} : o[e[11:8]],
                  e[7:0]);
        end
    initial forever #12.5 ref_clk = ~ref_clk;
    // Watchdog: a hang counts as a failure
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            res[i] = 8'($random(seed));
            cfg[i] = 8'($random(seed));
        end
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        expect_all(8'h00, 8'h00);
        $display("test enable rise done");
        for (int i = 0; i < 8; i++) host.put(ADR[i], cfg[i]);
        // Each source bit alone with reserved bits set, then all together
        for (int i = 0; i < 6; i++) begin
            b = i < 5 ? 8'hc8 | 8'h01 << BT[i] : 8'hff;
            host.mode(b, i[0], i);
            @(negedge ref_clk);
            expect_all(b, b);
        end
        host.put(8'h46, 8'h10);
        @(negedge ref_clk);
        expect_all(8'h10, 8'h00);
        @(negedge ref_clk);
        // Latch B keeps the last mode byte, masked like latch A
        rd_addr = 8'h47;
        expect_all(8'hff, 8'h00);
        $display("test source select done");
        host.put(8'h46, 8'hff);
        enable = 1'b0;
        repeat (2) @(negedge ref_clk);
        expect_all(8'h00, 8'h00);
        for (int i = 0; i < 8; i++) res[i] = 8'($random(seed));
        rd_addr = 8'h30;
        enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        expect_all(8'h00, 8'h00);
        $display("test toggle done");
        @(negedge ref_clk);
        print_verdict();
    end
endmodule
